// >>> design/gpts_defs.svh
`ifndef GPTS_DEFS_SVH
`define GPTS_DEFS_SVH
// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define GPTS_T1CTL_ADDR 4'h0
`define GPTS_T1CNT_ADDR 4'h1
`define GPTS_T1PER_ADDR 4'h2
`define GPTS_T2CTL_ADDR 4'h3
`define GPTS_T2CNT_ADDR 4'h4
`define GPTS_T2PER_ADDR 4'h5
`define GPTS_T3CTL_ADDR 4'h6
`define GPTS_T3CNT_ADDR 4'h7
`define GPTS_T3PER_ADDR 4'h8
`define GPTS_IRQ_STAT_ADDR 4'h9
`define GPTS_IRQ_MASK_ADDR 4'hA
// ****************************************
// control field positions
// ****************************************
`define GPTS_RUN_BIT 15
`define GPTS_IDLE_BIT 13
`define GPTS_GATE_BIT 6
`define GPTS_PS_HI 5
`define GPTS_PS_LO 4
`define GPTS_PAIR_BIT 3
`define GPTS_SYNC_BIT 2
`define GPTS_CS_BIT 1
// implemented bits per control register
`define GPTS_T1_MASK 16'hA076
`define GPTS_T2_MASK 16'hA07A
`define GPTS_T3_MASK 16'hA072
`define GPTS_CTL_RESET 16'h0000
`define GPTS_PER_RESET 16'hFFFF
// ****************************************
// prescale terminal counts
// ****************************************
`define GPTS_PS1_TC 8'h00
`define GPTS_PS8_TC 8'h07
`define GPTS_PS64_TC 8'h3F
`define GPTS_PS256_TC 8'hFF
`endif

// >>> design/gpts_pkg.sv
package gpts_pkg;
  typedef enum logic [2:0] {
    GPTS_ST_RESET = 3'h1,
    GPTS_ST_RUN = 3'h2,
    GPTS_ST_DONE = 3'h4
  } gpts_phase_t;

  typedef struct packed {
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] ctl3;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] cnt3;
    logic [15:0] per1;
    logic [15:0] per2;
    logic [15:0] per3;
    logic [7:0] ps1;
    logic [7:0] ps2;
    logic [7:0] ps3;
    logic [2:0] ext1_prev;
    logic [2:0] ext2_prev;
    logic [2:0] ext3_prev;
    logic [2:0] gate_prev;
    logic [1:0] t1_sync;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] rdata;
    logic irq;
    logic adc_trig;
    gpts_phase_t phase;
  } gpts_state_t;
endpackage

// >>> design/gpts_timer_set.sv
`timescale 1ns/1ns
`include "gpts_defs.svh"
// Operation
// - timer1 run bit starts and stops counting
// - idle-stop bit halts timer in idle
// - gate bit only acts with internal clock
// - prescale codes 1, 8, 64, 256
// - timer1 sync bit only with external clock
// - timer1 clock source: pin edge or internal
// - timers 2/3 clock source likewise
// - pair bit joins timers 2 and 3
// - timer2 low word, timer3 high word
// - paired, timer3 control has no effect
// - paired match raises timer3 flag
// - paired period is period3:period2
// - timer2 run bit runs pair or timer2
// - timers 2/3 have no asynchronous mode
// - only paired timer makes adc trigger
// - unimplemented control bits read zero
// - period match clears count, keeps counting
// - timer1 irq on match or gate fall
module gpts_timer_set
  import gpts_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic idle_in,
  input wire logic [2:0] ext_clk_in,
  input wire logic [2:0] gate_in,
  output logic [15:0] rdata_out,
  output logic irq_out,
  output logic adc_trig_out
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] ps_tc(input logic [15:0] ctl);
    case (ctl[`GPTS_PS_HI:`GPTS_PS_LO])
      2'b00: ps_tc = `GPTS_PS1_TC;
      2'b01: ps_tc = `GPTS_PS8_TC;
      2'b10: ps_tc = `GPTS_PS64_TC;
      default: ps_tc = `GPTS_PS256_TC;
    endcase
  endfunction

  // one timer input tick: source, gating, idle, run
  function automatic logic src_tick(input logic [15:0] ctl, input logic ext_rise,
                                    input logic gate);
    logic active;
    active = ctl[`GPTS_RUN_BIT] && !(idle_in && ctl[`GPTS_IDLE_BIT]);
    if (ctl[`GPTS_CS_BIT]) begin
      src_tick = active && ext_rise;
    end else begin
      src_tick = active && (!ctl[`GPTS_GATE_BIT] || gate);
    end
  endfunction

  gpts_state_t s_q;
  gpts_state_t s_d;
  logic [2:0] rise;
  logic t1_ext_edge;
  logic pair;
  logic [2:0] tick;
  logic [2:0] ev;
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic gfall1;

  // while paired, timer3's own prescaler and control bits sit idle
  assign pair = s_q.ctl2[`GPTS_PAIR_BIT];
  assign cnt32 = {s_q.cnt3, s_q.cnt2};
  assign per32 = {s_q.per3, s_q.per2};
  assign rise = ext_clk_in & ~s_q.ext1_prev;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    ev = 3'h0;
    tick = 3'h0;
    s_d.ext1_prev = ext_clk_in;
    s_d.gate_prev = gate_in;
    s_d.t1_sync = {s_q.t1_sync[0], ext_clk_in[0]};
    s_d.adc_trig = 1'b0;
    s_d.phase = GPTS_ST_RUN;
    // unsynchronised path still sampled once: inputs are taken as synchronous
    t1_ext_edge = s_q.ctl1[`GPTS_SYNC_BIT] ? (s_q.t1_sync[0] && !s_q.t1_sync[1])
                                         : rise[0];
    gfall1 = s_q.gate_prev[0] && !gate_in[0] && s_q.ctl1[`GPTS_GATE_BIT]
             && !s_q.ctl1[`GPTS_CS_BIT] && s_q.ctl1[`GPTS_RUN_BIT];
    // ****************************************
    // prescalers
    // ****************************************
    if (src_tick(s_q.ctl1, t1_ext_edge, gate_in[0])) begin
      if (s_q.ps1 >= ps_tc(s_q.ctl1)) begin
        s_d.ps1 = 8'h00;
        tick[0] = 1'b1;
      end else begin
        s_d.ps1 = s_q.ps1 + 8'h01;
      end
    end
    // timers 2/3 only synchronous paths: no asynchronous mode
    if (src_tick(s_q.ctl2, rise[1], gate_in[1])) begin
      if (s_q.ps2 >= ps_tc(s_q.ctl2)) begin
        s_d.ps2 = 8'h00;
        tick[1] = 1'b1;
      end else begin
        s_d.ps2 = s_q.ps2 + 8'h01;
      end
    end
    if (!pair && src_tick(s_q.ctl3, rise[2], gate_in[2])) begin
      if (s_q.ps3 >= ps_tc(s_q.ctl3)) begin
        s_d.ps3 = 8'h00;
        tick[2] = 1'b1;
      end else begin
        s_d.ps3 = s_q.ps3 + 8'h01;
      end
    end
    // ****************************************
    // counters
    // ****************************************
    if (tick[0]) begin
      if (s_q.cnt1 == s_q.per1) begin
        s_d.cnt1 = 16'h0000;
        ev[0] = 1'b1;
      end else begin
        s_d.cnt1 = s_q.cnt1 + 16'h0001;
      end
    end
    if (gfall1) begin
      ev[0] = 1'b1;
    end
    if (pair) begin
      if (tick[1]) begin
        if (cnt32 == per32) begin
          {s_d.cnt3, s_d.cnt2} = 32'h0000_0000;
          ev[2] = 1'b1;
          s_d.adc_trig = 1'b1;
        end else begin
          {s_d.cnt3, s_d.cnt2} = cnt32 + 32'h0000_0001;
        end
      end
    end else begin
      if (tick[1]) begin
        if (s_q.cnt2 == s_q.per2) begin
          s_d.cnt2 = 16'h0000;
          ev[1] = 1'b1;
        end else begin
          s_d.cnt2 = s_q.cnt2 + 16'h0001;
        end
      end
      if (tick[2]) begin
        if (s_q.cnt3 == s_q.per3) begin
          s_d.cnt3 = 16'h0000;
          ev[2] = 1'b1;
        end else begin
          s_d.cnt3 = s_q.cnt3 + 16'h0001;
        end
      end
    end
    // ****************************************
    // register writes
    // ****************************************
    if (wr_in) begin
      // a control write restarts its prescaler, so a smaller ratio never overruns
      case (addr_in)
        `GPTS_T1CTL_ADDR: begin
          s_d.ctl1 = wdata_in & `GPTS_T1_MASK;
          s_d.ps1 = 8'h00;
        end
        `GPTS_T2CTL_ADDR: begin
          s_d.ctl2 = wdata_in & `GPTS_T2_MASK;
          s_d.ps2 = 8'h00;
        end
        `GPTS_T3CTL_ADDR: begin
          s_d.ctl3 = wdata_in & `GPTS_T3_MASK;
          s_d.ps3 = 8'h00;
        end
        `GPTS_T1CNT_ADDR: s_d.cnt1 = wdata_in;
        `GPTS_T2CNT_ADDR: s_d.cnt2 = wdata_in;
        `GPTS_T3CNT_ADDR: s_d.cnt3 = wdata_in;
        `GPTS_T1PER_ADDR: s_d.per1 = wdata_in;
        `GPTS_T2PER_ADDR: s_d.per2 = wdata_in;
        `GPTS_T3PER_ADDR: s_d.per3 = wdata_in;
        `GPTS_IRQ_STAT_ADDR: s_d.irq_stat = s_q.irq_stat & ~wdata_in[2:0];
        `GPTS_IRQ_MASK_ADDR: s_d.irq_mask = wdata_in[2:0];
        default: s_d.irq_mask = s_q.irq_mask;
      endcase
    end
    // ****************************************
    // interrupts
    // ****************************************
    // set wins over a same-cycle clear
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    // ****************************************
    // read port: data in the cycle after the strobe
    // ****************************************
    s_d.rdata = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        `GPTS_T1CTL_ADDR: s_d.rdata = s_q.ctl1;
        `GPTS_T2CTL_ADDR: s_d.rdata = s_q.ctl2;
        `GPTS_T3CTL_ADDR: s_d.rdata = s_q.ctl3;
        `GPTS_T1CNT_ADDR: s_d.rdata = s_q.cnt1;
        `GPTS_T2CNT_ADDR: s_d.rdata = s_q.cnt2;
        `GPTS_T3CNT_ADDR: s_d.rdata = s_q.cnt3;
        `GPTS_T1PER_ADDR: s_d.rdata = s_q.per1;
        `GPTS_T2PER_ADDR: s_d.rdata = s_q.per2;
        `GPTS_T3PER_ADDR: s_d.rdata = s_q.per3;
        `GPTS_IRQ_STAT_ADDR: s_d.rdata = {13'h0000, s_q.irq_stat};
        `GPTS_IRQ_MASK_ADDR: s_d.rdata = {13'h0000, s_q.irq_mask};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{
        ctl1: `GPTS_CTL_RESET,
        ctl2: `GPTS_CTL_RESET,
        ctl3: `GPTS_CTL_RESET,
        cnt1: 16'h0000,
        cnt2: 16'h0000,
        cnt3: 16'h0000,
        per1: `GPTS_PER_RESET,
        per2: `GPTS_PER_RESET,
        per3: `GPTS_PER_RESET,
        ps1: 8'h00,
        ps2: 8'h00,
        ps3: 8'h00,
        ext1_prev: 3'h0,
        ext2_prev: 3'h0,
        ext3_prev: 3'h0,
        gate_prev: 3'h0,
        t1_sync: 2'h0,
        irq_stat: 3'h0,
        irq_mask: 3'h0,
        rdata: 16'h0000,
        irq: 1'b0,
        adc_trig: 1'b0,
        phase: GPTS_ST_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
  assign adc_trig_out = s_q.adc_trig;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ****************************************
  // timer checks
  // ****************************************
  run_stop_a: assert property (
    !s_q.ctl1[`GPTS_RUN_BIT] && !(wr_in && addr_in == `GPTS_T1CNT_ADDR)
    |=> $stable(s_q.cnt1))
    else $error("timer1 counted while stopped");
  idle_halt_a: assert property (
    idle_in && s_q.ctl2[`GPTS_IDLE_BIT] && !wr_in |=> $stable(s_q.cnt2) && $stable(s_q.ps2))
    else $error("timer2 ran in idle");
  t1_idle_a: assert property (
    idle_in && s_q.ctl1[`GPTS_IDLE_BIT] && !wr_in |=> $stable(s_q.cnt1) && $stable(s_q.ps1))
    else $error("timer1 ran in idle");
  gate_block_a: assert property (
    s_q.ctl1[`GPTS_GATE_BIT] && !s_q.ctl1[`GPTS_CS_BIT] && !gate_in[0] && !wr_in
    |=> $stable(s_q.ps1))
    else $error("gate ignored");
  ps8_wrap_a: assert property (
    s_q.ctl1[`GPTS_PS_HI:`GPTS_PS_LO] == 2'b01 && !wr_in |=> s_q.ps1 <= 8'h07)
    else $error("prescale 8 overrun");
  ext_only_a: assert property (
    s_q.ctl2[`GPTS_CS_BIT] && !rise[1] && !wr_in |=> $stable(s_q.ps2))
    else $error("timer2 counted without pin edge");
  t3_ext_a: assert property (
    !pair && s_q.ctl3[`GPTS_RUN_BIT] && s_q.ctl3[`GPTS_CS_BIT] && !idle_in
    && s_q.ctl3[`GPTS_PS_HI:`GPTS_PS_LO] == 2'h0 && rise[2] && s_q.cnt3 != s_q.per3 && !wr_in
    |=> s_q.cnt3 == $past(s_q.cnt3) + 16'h0001)
    else $error("timer3 missed a pin edge");
  wrap_zero_a: assert property (
    tick[0] && s_q.cnt1 == s_q.per1 && !wr_in
    |=> s_q.cnt1 == 16'h0000 && s_q.irq_stat[0])
    else $error("no wrap");
  t2_wrap_a: assert property (
    !pair && tick[1] && s_q.cnt2 == s_q.per2 && !wr_in
    |=> s_q.cnt2 == 16'h0000 && s_q.irq_stat[1])
    else $error("timer2 no wrap");
  t3_wrap_a: assert property (
    !pair && tick[2] && s_q.cnt3 == s_q.per3 && !wr_in
    |=> s_q.cnt3 == 16'h0000 && s_q.irq_stat[2])
    else $error("timer3 no wrap");
  run2_stop_a: assert property (
    !s_q.ctl2[`GPTS_RUN_BIT] && !wr_in |=> $stable(s_q.cnt2))
    else $error("timer2 counted while stopped");
  pair_hold_a: assert property (
    pair && !s_q.ctl2[`GPTS_RUN_BIT] && !wr_in |=> $stable(s_q.cnt3))
    else $error("pair high word moved while stopped");
  pair_carry_a: assert property (
    pair && tick[1] && cnt32 != per32 && !wr_in
    |=> {s_q.cnt3, s_q.cnt2} == $past(cnt32) + 32'h0000_0001)
    else $error("pair count did not carry");
  pair_flag_a: assert property (
    pair && !wr_in |=> !$rose(s_q.irq_stat[1]))
    else $error("timer2 flag set in pair mode");
  pair_adc_a: assert property (
    pair && tick[1] && cnt32 == per32 |=> adc_trig_out && s_q.irq_stat[2])
    else $error("pair match without trigger");
  adc_pair_a: assert property (
    s_q.adc_trig |-> $past(pair))
    else $error("adc trigger without pair");
  t3_ignored_a: assert property (
    pair && !wr_in |=> $stable(s_q.ps3))
    else $error("timer3 prescaler ran in pair mode");
  // ****************************************
  // bus and interrupt checks
  // ****************************************
  ctl_zero_a: assert property (
    (s_q.ctl1 & ~`GPTS_T1_MASK) == 16'h0000 && (s_q.ctl2 & ~`GPTS_T2_MASK) == 16'h0000)
    else $error("reserved bit set");
  ctl3_zero_a: assert property (
    (s_q.ctl3 & ~`GPTS_T3_MASK) == 16'h0000)
    else $error("timer3 reserved bit set");
  rdata_idle_a: assert property (
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data without strobe");
  unmapped_rd_a: assert property (
    rd_in && addr_in > `GPTS_IRQ_MASK_ADDR |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  stat_clear_a: assert property (
    wr_in && addr_in == `GPTS_IRQ_STAT_ADDR && wdata_in[0] && !ev[0]
    |=> !s_q.irq_stat[0])
    else $error("status not cleared");
  gate_fall_a: assert property (
    gfall1 |=> s_q.irq_stat[0])
    else $error("gate fall did not flag");
  irq_level_a: assert property (
    irq_out == |(s_q.irq_stat & s_q.irq_mask))
    else $error("irq level wrong");
  pair_wrap_c: cover property (pair && tick[1] && cnt32 == per32);
  gate_fall_c: cover property (gfall1);
  sync_edge_c: cover property (s_q.ctl1[`GPTS_SYNC_BIT] && tick[0]);
  idle_hold_c: cover property (idle_in && s_q.ctl1[`GPTS_IDLE_BIT] && s_q.ctl1[`GPTS_RUN_BIT]);
  t2_wrap_c: cover property (!pair && tick[1] && s_q.cnt2 == s_q.per2);
endmodule

// >>> bench/test_gated_prescaled_timer_set.sv
`timescale 1ns/1ns
`include "gpts_defs.svh"
module test_gated_prescaled_timer_set;
  logic clk_in, arst_n_in, wr_in, rd_in, idle_in;
  logic [3:0] addr_in;
  logic [15:0] wdata_in, rdata_out, rv, a, b;
  logic [2:0] ext_clk_in, gate_in;
  logic irq_out, adc_trig_out;
  int mismatches, check_count, cycles, adc_cnt, i;
  logic [3:0] ca [3] = '{`GPTS_T1CTL_ADDR, `GPTS_T2CTL_ADDR, `GPTS_T3CTL_ADDR};
  logic [15:0] mk [3] = '{`GPTS_T1_MASK, `GPTS_T2_MASK, `GPTS_T3_MASK};
  int rt [4] = '{1, 8, 64, 256};
  logic [15:0] ev [4] = '{16'h8046, 16'h8042, 16'h8042, 16'h8042};
  int et [4] = '{0, 0, 1, 2};

  gpts_timer_set dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .idle_in(idle_in),
    .ext_clk_in(ext_clk_in), .gate_in(gate_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .adc_trig_out(adc_trig_out));

  always #5 clk_in = ~clk_in;

  // the ceiling is nearly twenty times the length of the sequence below
  always @(posedge clk_in) begin
    cycles++;
    if (adc_trig_out === 1'b1) adc_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task chkb(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task rc(input string n, input logic [3:0] ad, input logic [15:0] e);
    rd(ad, rv);
    chk(n, e, rv);
  endtask

  // two count reads gap+2 cycles apart; checks how far the count moved
  task diff(input string n, input logic [3:0] ad, input int gap, input logic [15:0] e);
    rd(ad, a);
    repeat (gap) @(posedge clk_in);
    rd(ad, b);
    chk(n, e, b - a);
  endtask

  task pulses(input int p, input int k);
    repeat (k) begin
      @(posedge clk_in);
      ext_clk_in[p] <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_clk_in[p] <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    clk_in = 1'b0; arst_n_in = 1'b0; addr_in = 4'h0; wdata_in = 16'h0000;
    wr_in = 1'b0; rd_in = 1'b0; idle_in = 1'b0; ext_clk_in = 3'h0; gate_in = 3'h0;
    mismatches = 0; check_count = 0; cycles = 0; adc_cnt = 0;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rc("ctl reset", ca[i], 16'h0000);
      rc("per reset", ca[i] + 4'h2, 16'hFFFF);
      wr(ca[i], 16'h5FFF);
      rc("ctl unimpl", ca[i], 16'h5FFF & mk[i]);
      wr(ca[i], 16'h0000);
    end
    rc("unmapped", 4'hB, 16'h0000);
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      wr(`GPTS_T1CNT_ADDR, 16'h0000);
      wr(`GPTS_T1CTL_ADDR, 16'h8000 | 16'(i << 4));
      diff("prescale", `GPTS_T1CNT_ADDR, 2 * rt[i] - 2, 16'h0002);
    end
    wr(`GPTS_T1CTL_ADDR, 16'h0000);
    diff("stopped", `GPTS_T1CNT_ADDR, 4, 16'h0000);
    wr(`GPTS_T1CTL_ADDR, 16'hA000);
    idle_in <= 1'b1;
    diff("idle stop", `GPTS_T1CNT_ADDR, 0, 16'h0000);
    wr(`GPTS_T1CTL_ADDR, 16'h8000);
    diff("idle run", `GPTS_T1CNT_ADDR, 0, 16'h0002);
    idle_in <= 1'b0;
    wr(`GPTS_T1CTL_ADDR, 16'h8040);
    diff("gate low", `GPTS_T1CNT_ADDR, 0, 16'h0000);
    gate_in[0] <= 1'b1;
    diff("gate high", `GPTS_T1CNT_ADDR, 0, 16'h0002);
    wr(`GPTS_IRQ_STAT_ADDR, 16'h0007);
    gate_in[0] <= 1'b0;
    repeat (3) @(posedge clk_in);
    rc("gate fall", `GPTS_IRQ_STAT_ADDR, 16'h0001);
    $display("timer1 internal test done");
    // gate bit set and gate low: external counting must ignore it
    for (i = 0; i < 4; i++) begin
      wr(ca[et[i]] + 4'h1, 16'h0000);
      wr(ca[et[i]], ev[i]);
      rd(ca[et[i]] + 4'h1, a);
      pulses(et[i], 5);
      repeat (4) @(posedge clk_in);
      rd(ca[et[i]] + 4'h1, b);
      chk("ext edges", 16'h0005, b - a);
      wr(ca[et[i]], 16'h0000);
    end
    $display("external clock test done");
    wr(`GPTS_T1CNT_ADDR, 16'h0000);
    wr(`GPTS_T1PER_ADDR, 16'h0002);
    wr(`GPTS_IRQ_STAT_ADDR, 16'h0007);
    wr(`GPTS_IRQ_MASK_ADDR, 16'h0000);
    adc_cnt = 0;
    wr(`GPTS_T1CTL_ADDR, 16'h8000);
    repeat (8) @(posedge clk_in);
    #1;
    chkb("irq masked", 1'b0, irq_out);
    rc("t1 match", `GPTS_IRQ_STAT_ADDR, 16'h0001);
    wr(`GPTS_IRQ_MASK_ADDR, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1;
    chkb("irq on", 1'b1, irq_out);
    wr(`GPTS_T1CTL_ADDR, 16'h0000);
    wr(`GPTS_IRQ_STAT_ADDR, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1;
    chkb("irq cleared", 1'b0, irq_out);
    wr(`GPTS_T2PER_ADDR, 16'h0003);
    wr(`GPTS_T2CNT_ADDR, 16'h0000);
    wr(`GPTS_T2CTL_ADDR, 16'h8000);
    repeat (20) @(posedge clk_in);
    wr(`GPTS_T2CTL_ADDR, 16'h0000);
    rc("t2 match", `GPTS_IRQ_STAT_ADDR, 16'h0002);
    chk("adc single", 16'h0000, 16'(adc_cnt));
    $display("interrupt test done");
    wr(`GPTS_T3PER_ADDR, 16'h0001);
    wr(`GPTS_T2CNT_ADDR, 16'hFFFE);
    wr(`GPTS_T3CNT_ADDR, 16'h0000);
    wr(`GPTS_IRQ_STAT_ADDR, 16'h0007);
    adc_cnt = 0;
    wr(`GPTS_T2CTL_ADDR, 16'h8018);
    repeat (25) @(posedge clk_in);
    rc("pair carry", `GPTS_T3CNT_ADDR, 16'h0001);
    repeat (40) @(posedge clk_in);
    wr(`GPTS_T2CTL_ADDR, 16'h0000);
    rc("pair flag", `GPTS_IRQ_STAT_ADDR, 16'h0004);
    rc("pair wrap", `GPTS_T3CNT_ADDR, 16'h0000);
    chk("adc pair", 16'h0001, 16'(adc_cnt));
    $display("paired timer test done");
    tally_and_finish();
  end
endmodule
